// *** hw/spf_pkg.sv ***
/*
 spf_pkg: constants and carrier types of the framed serial port.
 assumes a 20 MHz system clock and a 32-bit classic Wishbone bus.
*/
package spf_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_STAT = 10'h240;
    localparam logic [9:0] IDX_CON1 = 10'h242;
    localparam logic [9:0] IDX_CON2 = 10'h244;
    localparam logic [9:0] IDX_BUF = 10'h246;
    localparam logic [15:0] RST_VAL = 16'h0000;
    // status/control fields
    localparam int B_EN = 15;
    localparam int B_SIDL = 13;
    localparam int B_ROV = 6;
    localparam int B_TBF = 1;
    localparam int B_RBF = 0;
    localparam logic [15:0] STAT_WMASK = 16'ha000;
    // primary control fields
    localparam int B_CLOCK_PIN_DISABLE = 12;
    localparam int B_DATA_OUT_DISABLE = 11;
    localparam int B_WIDE = 10;
    localparam int B_SMP = 9;
    localparam int B_CKE = 8;
    localparam int B_SLAVE_SELECT_ENABLE = 7;
    localparam int B_CKP = 6;
    localparam int B_MST = 5;
    localparam int B_SPRE = 2;
    localparam int B_PPRE = 0;
    localparam logic [15:0] CON1_WMASK = 16'h1fff;
    // framing control fields
    localparam int B_FRM = 15;
    localparam int B_FSD = 14;
    localparam int B_FPOL = 13;
    localparam int B_FDLY = 1;
    localparam logic [15:0] CON2_WMASK = 16'he002;
    // shortest serial clock period in system cycles
    localparam logic [9:0] MIN_PERIOD = 10'h002;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] WORD_BITS = 5'h10;

    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss;
    } spf_pin_in_t;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic sdo;
        logic sdo_oe;
        logic ss;
        logic ss_oe;
    } spf_pin_out_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_SHIFT
    } spf_state_t;
endpackage

// *** hw/spf_top.sv ***
/*
 spf_top: framed serial port, master or slave, with Wishbone registers.
 assumes pins already resolved to in/out/enable by the surroundings,
 and idle_mode_i coming from logic on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module spf_top
    import spf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic idle_mode_i,
    input wire spf_pkg::spf_pin_in_t pins_i,
    output spf_pkg::spf_pin_out_t pins_o,
    output logic xfer_done_o
);
    import spf_pkg::*;

    logic [15:0] stat_q, con1_q, con2_q, txb_q, rxb_q;
    logic tbf_q, rbf_q, rov_q, ack_q;
    logic [31:0] dat_q;
    logic [2:0] sck_sy_q, sdi_sy_q, ss_sy_q;
    spf_state_t st_q;
    logic [9:0] cnt_q;
    logic [4:0] bit_q;
    logic [15:0] tx_q, rx_q;
    logic sdo_q, sck_q, frame_q, loaded_q, fseen_q, done_q;

    // bus decode
    logic acc, wr, rd_buf, wr_buf;
    logic [9:0] idx;
    logic [15:0] wmask;
    assign idx = adr_i[11:2];
    assign acc = cyc_i & stb_i & ~ack_q;
    assign wr = acc & we_i;
    assign wr_buf = wr & (idx == IDX_BUF);
    assign rd_buf = acc & ~we_i & (idx == IDX_BUF);
    assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

    // control fields
    logic en, sidl, clock_pin_disable, data_out_disable, wide, input_sample_phase, cke, slave_select_enable, clock_idle_polarity, mst;
    logic frm, fsd, fpol, fdly;
    assign en = stat_q[B_EN];
    assign sidl = stat_q[B_SIDL];
    assign clock_pin_disable = con1_q[B_CLOCK_PIN_DISABLE];
    assign data_out_disable = con1_q[B_DATA_OUT_DISABLE];
    assign wide = con1_q[B_WIDE];
    assign input_sample_phase = con1_q[B_SMP];
    assign cke = con1_q[B_CKE];
    assign slave_select_enable = con1_q[B_SLAVE_SELECT_ENABLE];
    assign clock_idle_polarity = con1_q[B_CKP];
    assign mst = con1_q[B_MST];
    assign frm = con2_q[B_FRM];
    assign fsd = con2_q[B_FSD];
    assign fpol = con2_q[B_FPOL];
    assign fdly = con2_q[B_FDLY];

    // pin synchronisers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sck_sy_q <= 3'h0;
            sdi_sy_q <= 3'h0;
            ss_sy_q <= 3'h7;
        end
        else
        begin
            sck_sy_q <= {sck_sy_q[1:0], pins_i.sck};
            sdi_sy_q <= {sdi_sy_q[1:0], pins_i.sdi};
            ss_sy_q <= {ss_sy_q[1:0], pins_i.ss};
        end
    end

    logic sck_s, sck_p, sdi_s, ss_s;
    assign sck_s = sck_sy_q[1];
    assign sck_p = sck_sy_q[2];
    assign sdi_s = sdi_sy_q[1];
    assign ss_s = ss_sy_q[1];

    // divider ratio: primary times secondary
    logic [9:0] pdiv, sdiv, ps, half;
    always_comb
    begin
        case (con1_q[B_PPRE +: 2])
            2'h3: pdiv = 10'h001;
            2'h2: pdiv = 10'h004;
            2'h1: pdiv = 10'h010;
            default: pdiv = 10'h040;
        endcase
        sdiv = 10'h008 - {7'h0, con1_q[B_SPRE +: 3]};
        ps = 10'((pdiv * sdiv));
        if (ps < MIN_PERIOD)
        begin
            ps = MIN_PERIOD;
        end
        half = ps >> 1;
    end

    logic halt, cke_e, fs_act, sel_ok, run;
    logic [4:0] nbits;
    logic top_tx, top_b;
    assign halt = sidl & idle_mode_i;
    assign cke_e = cke & ~frm;
    assign nbits = wide ? WORD_BITS : BYTE_BITS;
    assign top_tx = wide ? tx_q[15] : tx_q[7];
    assign top_b = wide ? txb_q[15] : txb_q[7];
    assign fs_act = (ss_s == fpol);
    assign sel_ok = ~slave_select_enable | frm | ~ss_s;
    assign run = (st_q == ST_SHIFT);

    // clock events
    logic lead, trail, last, chg, mid, endv, samp, done, go, sload;
    logic [15:0] rx_nx;
    always_comb
    begin
        if (mst)
        begin
            lead = run & (cnt_q == 10'h000);
            trail = run & (cnt_q == half);
            last = run & (cnt_q == ps - 10'h001);
        end
        else
        begin
            // slave follows the incoming clock, frozen on overflow
            lead = en & ~halt & ~rov_q & sel_ok & (sck_s != sck_p)
                & (sck_s == ~clock_idle_polarity);
            trail = en & ~halt & ~rov_q & sel_ok & (sck_s != sck_p)
                & (sck_s == clock_idle_polarity);
            last = 1'b0;
        end
        chg = cke_e ? trail : lead;
        mid = cke_e ? lead : trail;
        endv = cke_e ? trail : last;
        samp = (mst & input_sample_phase) ? endv : mid;
        if (!mst && frm && fsd && !fseen_q && !fs_act)
        begin
            samp = 1'b0;
            chg = 1'b0;
        end
        rx_nx = samp ? {rx_q[14:0], sdi_s} : rx_q;
        if (mst)
        begin
            done = last & (bit_q == nbits - 5'h01);
        end
        else
        begin
            done = samp & (bit_q == nbits - 5'h01);
        end
        go = en & mst & ~clock_pin_disable & ~halt & ~rov_q & tbf_q
            & (~frm | ~fsd | fs_act);
        sload = en & ~mst & ~halt & tbf_q & ~loaded_q
            & (bit_q == 5'h00);
    end

    // master sequencer and bit counter
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 10'h000;
        end
        else if (!halt)
        begin
            case (st_q)
                ST_IDLE:
                begin
                    cnt_q <= 10'h000;
                    if (go)
                    begin
                        st_q <= (frm && !fsd && !fdly) ? ST_FRAME : ST_SHIFT;
                    end
                end
                ST_FRAME:
                begin
                    cnt_q <= (cnt_q == ps - 10'h001) ? 10'h000 : cnt_q + 10'h001;
                    if (cnt_q == ps - 10'h001)
                    begin
                        st_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    cnt_q <= last ? 10'h000 : cnt_q + 10'h001;
                    if (done || !mst || clock_pin_disable)
                    begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en || (!mst && !sel_ok))
        begin
            bit_q <= 5'h00;
        end
        else if (done)
        begin
            bit_q <= 5'h00;
        end
        else if (mst ? last : samp)
        begin
            bit_q <= bit_q + 5'h01;
        end
    end

    // shifters and serial output
    logic load;
    assign load = (st_q == ST_IDLE && go && !halt) | sload;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_q <= RST_VAL;
            rx_q <= RST_VAL;
            sdo_q <= 1'b0;
        end
        else
        begin
            rx_q <= done ? RST_VAL : rx_nx;
            if (load)
            begin
                tx_q <= cke_e ? (txb_q << 1) : txb_q;
                if (cke_e)
                begin
                    sdo_q <= top_b;
                end
            end
            else if (chg)
            begin
                sdo_q <= top_tx;
                tx_q <= tx_q << 1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en)
        begin
            loaded_q <= 1'b0;
            fseen_q <= 1'b0;
        end
        else
        begin
            loaded_q <= done ? 1'b0 : (loaded_q | sload);
            fseen_q <= done ? 1'b0 : (fseen_q | (fs_act & fsd & frm));
        end
    end

    // clock and frame pulse outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sck_q <= 1'b0;
            frame_q <= 1'b0;
        end
        else
        begin
            sck_q <= clock_idle_polarity ^ (run & mst & (cnt_q < half));
            if (mst)
            begin
                frame_q <= (st_q == ST_FRAME) | (run & fdly & (bit_q == 5'h00));
            end
            else
            begin
                frame_q <= (loaded_q | sload) & (bit_q == 5'h00);
            end
        end
    end

    always_comb
    begin
        pins_o.sck = sck_q;
        pins_o.sck_oe = en & mst & ~clock_pin_disable;
        pins_o.sdo = sdo_q;
        pins_o.sdo_oe = en & ~data_out_disable & (mst | sel_ok);
        pins_o.ss = frame_q ? fpol : ~fpol;
        pins_o.ss_oe = en & frm & ~fsd;
    end

    // flags
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tbf_q <= 1'b0;
            rbf_q <= 1'b0;
            rov_q <= 1'b0;
            rxb_q <= RST_VAL;
            done_q <= 1'b0;
        end
        else
        begin
            tbf_q <= wr_buf | (tbf_q & ~load);
            done_q <= done;
            if (done && rbf_q && !rd_buf)
            begin
                rov_q <= 1'b1;
                rbf_q <= 1'b1;
            end
            else
            begin
                if (wr && idx == IDX_STAT && sel_i[0] && !dat_i[B_ROV])
                begin
                    rov_q <= 1'b0;
                end
                if (done)
                begin
                    rbf_q <= 1'b1;
                    rxb_q <= wide ? rx_nx : {8'h00, rx_nx[7:0]};
                end
                else if (rd_buf)
                begin
                    rbf_q <= 1'b0;
                end
            end
        end
    end
    assign xfer_done_o = done_q;

    // register writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat_q <= RST_VAL;
            con1_q <= RST_VAL;
            con2_q <= RST_VAL;
            txb_q <= RST_VAL;
        end
        else if (wr)
        begin
            case (idx)
                IDX_STAT: stat_q <= (stat_q & ~(wmask & STAT_WMASK))
                    | (dat_i[15:0] & wmask & STAT_WMASK);
                IDX_CON1: con1_q <= (con1_q & ~(wmask & CON1_WMASK))
                    | (dat_i[15:0] & wmask & CON1_WMASK);
                IDX_CON2: con2_q <= (con2_q & ~(wmask & CON2_WMASK))
                    | (dat_i[15:0] & wmask & CON2_WMASK);
                IDX_BUF: txb_q <= (txb_q & ~wmask) | (dat_i[15:0] & wmask);
                default: txb_q <= txb_q;
            endcase
        end
    end

    // register reads and ack
    logic [15:0] rd;
    always_comb
    begin
        case (idx)
            IDX_STAT:
            begin
                rd = stat_q;
                rd[B_ROV] = rov_q;
                rd[B_TBF] = tbf_q;
                rd[B_RBF] = rbf_q;
            end
            IDX_CON1: rd = con1_q;
            IDX_CON2: rd = con2_q;
            IDX_BUF: rd = rxb_q;
            default: rd = RST_VAL;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end
        else
        begin
            ack_q <= acc;
            dat_q <= (acc && !we_i) ? {16'h0000, rd} : 32'h0;
        end
    end
    assign ack_o = ack_q;
    assign dat_o = dat_q;
endmodule
`default_nettype wire

// *** dv/spf_top_properties.sv ***
/*
 spf_top_properties: port checker for spf_top, bound below.
 assumes full 16-bit register writes (sel_i all ones).
*/
`timescale 1ns/100ps
`default_nettype none
module spf_top_properties
    import spf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic idle_mode_i,
    input wire spf_pkg::spf_pin_in_t pins_i,
    input wire spf_pkg::spf_pin_out_t pins_o,
    input wire logic xfer_done_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [15:0] st_q, c1_q;
    logic [9:0] per_q, p_exp;
    logic [4:0] e_q;
    logic [31:0] umask;
    logic sck_q, lead;
    assign lead = (sck_q == c1_q[B_CKP]) && (pins_o.sck != c1_q[B_CKP]);
    // shadow of written control bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= 16'h0000;
            c1_q <= 16'h0000;
        end
        else if (cyc_i && stb_i && !ack_o && we_i && adr_i[11:2] == IDX_STAT)
            st_q <= dat_i[15:0] & STAT_WMASK;
        else if (cyc_i && stb_i && !ack_o && we_i && adr_i[11:2] == IDX_CON1)
            c1_q <= dat_i[15:0] & CON1_WMASK;
    end
    // leading edge spacing and count
    always_ff @(posedge clk_i)
    begin
        sck_q <= pins_o.sck;
        per_q <= lead ? 10'h001 : per_q + 10'h001;
        if (rst_i || xfer_done_o || !st_q[B_EN])
            e_q <= 5'h00;
        else if (lead)
            e_q <= e_q + 5'h01;
    end
    always_comb
    begin
        case (c1_q[1:0])
            2'h3: p_exp = 10'h001;
            2'h2: p_exp = 10'h004;
            2'h1: p_exp = 10'h010;
            default: p_exp = 10'h040;
        endcase
        p_exp = p_exp * (10'h008 - {7'h00, c1_q[4:2]});
        if (p_exp < MIN_PERIOD)
            p_exp = MIN_PERIOD;
    end
    always_comb
    begin
        case (adr_i[11:2])
            IDX_STAT: umask = {16'hffff, ~16'ha043};
            IDX_CON1: umask = {16'hffff, ~CON1_WMASK};
            IDX_CON2: umask = {16'hffff, ~CON2_WMASK};
            IDX_BUF: umask = 32'hffff0000;
            default: umask = 32'hffffffff;
        endcase
    end
    chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_read_unimpl: assert property (ack_o && !we_i |-> (dat_o & umask) == 32'h0)
        else $error("unimplemented bits read nonzero");
    chk_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data without ack");
    chk_pins_off: assert property ($stable(st_q) && !st_q[B_EN] |->
        !pins_o.sck_oe && !pins_o.sdo_oe)
        else $error("pins driven while disabled");
    chk_sck_owner: assert property ($stable(st_q) && $stable(c1_q) |->
        pins_o.sck_oe == (st_q[B_EN] && c1_q[B_MST] && !c1_q[B_CLOCK_PIN_DISABLE]))
        else $error("clock pin enable wrong");
    chk_sdo_off: assert property ($stable(c1_q) && c1_q[B_DATA_OUT_DISABLE] |-> !pins_o.sdo_oe)
        else $error("data out driven while disabled");
    chk_sck_idle: assert property (xfer_done_o && pins_o.sck_oe |->
        pins_o.sck == c1_q[B_CKP])
        else $error("clock not idle at completion");
    chk_sck_period: assert property (lead && e_q != 5'h00 && c1_q[B_MST] |->
        per_q == p_exp)
        else $error("serial clock period wrong");
    chk_done_pulse: assert property (xfer_done_o |=> !xfer_done_o)
        else $error("done longer than one cycle");
    cov_done: cover property (xfer_done_o);
    cov_lead: cover property (lead && e_q == 5'h07);
    cov_stat_read: cover property (ack_o && !we_i && adr_i[11:2] == IDX_STAT);
endmodule
bind spf_top spf_top_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .idle_mode_i(idle_mode_i), .pins_i(pins_i), .pins_o(pins_o),
    .xfer_done_o(xfer_done_o));
`default_nettype wire

// *** dv/spf_peer.sv ***
/*
 spf_peer: far-side serial peripheral, shifts a word out and captures one.
 assumes its clock comes from the port in master mode.
*/
`timescale 1ns/100ps
`default_nettype none
module spf_peer
(
    input wire logic sck_i,
    input wire logic sck_oe_i,
    input wire logic pol_i,
    input wire logic sdo_i,
    input wire logic load_i,
    input wire logic [15:0] word_i,
    output logic sdi_o,
    output logic [15:0] got_o
);
    logic [15:0] tx_q;
    logic bit_q, act;
    assign act = sck_i ^ pol_i;
    // undriven look when clock released
    assign sdi_o = sck_oe_i ? bit_q : ~bit_q;
    // next bit on leading edge, msb first
    always @(posedge act or posedge load_i)
    begin
        if (load_i)
            tx_q <= word_i;
        else
        begin
            bit_q <= tx_q[15];
            tx_q <= {tx_q[14:0], 1'b0};
        end
    end
    // capture on trailing edge
    always @(negedge act)
        got_o <= {got_o[14:0], sdo_i};
endmodule
`default_nettype wire

// *** dv/spf_top_bench.sv ***
/*
 spf_top_bench: Wishbone register tasks and master transfers.
 assumes spf_peer on the serial pins and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module spf_top_bench;
    import spf_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, idle_mode_i, xfer_done_o;
    logic pol, load, sdi, s;
    logic [11:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [15:0] word, got;
    spf_pin_in_t pins_i;
    spf_pin_out_t pins_o;
    int fail_count, comparisons;
    logic [9:0] idx [4] = '{IDX_STAT, IDX_CON1, 10'h248, IDX_CON2};
    logic [15:0] wv [4] = '{16'hffff, 16'hfeff, 16'hffff, 16'hffff};
    logic [15:0] rv [4] = '{16'ha000, 16'h1eff, 16'h0000, 16'he002};
    logic [15:0] cfg [8] = '{16'h003d, 16'h023d, 16'h007d, 16'h043d,
        16'h0023, 16'h003a, 16'h0035, 16'h003c};
    assign pins_i = {1'b0, sdi, 1'b1};
    spf_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .idle_mode_i(idle_mode_i), .pins_i(pins_i), .pins_o(pins_o), .xfer_done_o(xfer_done_o));
    spf_peer peer (.sck_i(pins_o.sck), .sck_oe_i(pins_o.sck_oe), .pol_i(pol),
        .sdo_i(pins_o.sdo), .load_i(load), .word_i(word), .sdi_o(sdi), .got_o(got));
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic finish_test();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {a, 2'b00};
        dat_i <= {16'h0, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fail_count++;
            finish_test();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic wait_done(input logic must);
        s = 1'b0;
        for (int i = 0; i < 2000 && !s; i++)
        begin
            @(posedge clk_i);
            s = (xfer_done_o === 1'b1);
        end
        if (must && !s)
        begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic reload();
        load <= 1'b1;
        @(posedge clk_i);
        load <= 1'b0;
    endtask
    task automatic xfer(input logic [15:0] c1, input logic [15:0] tx);
        logic [15:0] m;
        m = c1[B_WIDE] ? 16'hffff : 16'h00ff;
        bus(1'b1, IDX_CON1, c1);
        pol <= c1[B_CKP];
        repeat (4) @(posedge clk_i);
        check({30'h0, pins_o.sck_oe, pins_o.sdo_oe}, 32'h3);
        reload();
        bus(1'b1, IDX_BUF, tx);
        wait_done(1'b1);
        check({16'h0, got & m}, {16'h0, tx & m});
        bus(1'b0, IDX_STAT, 16'h0);
        check(rd, 32'h8001);
        bus(1'b0, IDX_BUF, 16'h0);
        check(rd, {16'h0, c1[B_WIDE] ? word : {8'h0, word[15:8]}});
        bus(1'b0, IDX_STAT, 16'h0);
        check(rd, 32'h8000);
    endtask
    initial
    begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        finish_test();
    end
    initial
    begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 12'h000;
        sel_i = 4'hf;
        dat_i = 32'h0;
        idle_mode_i = 1'b0;
        pol = 1'b0;
        load = 1'b0;
        word = 16'hc3a5;
        fail_count = 0;
        comparisons = 0;
        do_reset();
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b0, IDX_STAT + 10'(2 * i), 16'h0);
            check(rd, 32'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, idx[i], wv[i]);
            bus(1'b0, idx[i], 16'h0);
            check(rd, {16'h0, rv[i]});
        end
        check({31'h0, pins_o.ss_oe}, 32'h0);
        check({31'h0, pins_o.sck_oe}, 32'h0);
        check({31'h0, pins_o.sdo_oe}, 32'h0);
        bus(1'b1, IDX_CON2, 16'ha000);
        repeat (2) @(posedge clk_i);
        check({30'h0, pins_o.ss_oe, pins_o.ss}, 32'h2);
        bus(1'b1, IDX_CON2, 16'h8000);
        repeat (2) @(posedge clk_i);
        check({30'h0, pins_o.ss_oe, pins_o.ss}, 32'h3);
        bus(1'b1, IDX_BUF, 16'h0011);
        bus(1'b0, IDX_STAT, 16'h0);
        check(rd, 32'ha002);
        do_reset();
        bus(1'b1, IDX_STAT, 16'h8000);
        // sample phase set only with master bit
        for (int i = 0; i < 8; i++)
            xfer(cfg[i], 16'h5a3c ^ 16'(i));
        reload();
        bus(1'b1, IDX_BUF, 16'h0011);
        wait_done(1'b1);
        bus(1'b1, IDX_BUF, 16'h0022);
        wait_done(1'b1);
        bus(1'b0, IDX_STAT, 16'h0);
        check(rd, 32'h8041);
        bus(1'b0, IDX_BUF, 16'h0);
        check(rd, {24'h0, word[15:8]});
        bus(1'b1, IDX_BUF, 16'h0033);
        wait_done(1'b0);
        check({31'h0, s}, 32'h0);
        bus(1'b0, IDX_STAT, 16'h0);
        check(rd, 32'h8042);
        do_reset();
        bus(1'b1, IDX_STAT, 16'ha000);
        bus(1'b1, IDX_CON1, 16'h003d);
        idle_mode_i <= 1'b1;
        bus(1'b1, IDX_BUF, 16'h0044);
        wait_done(1'b0);
        check({31'h0, s}, 32'h0);
        do_reset();
        bus(1'b1, IDX_STAT, 16'h8000);
        xfer(16'h003d, 16'h0055);
        finish_test();
    end
endmodule
`default_nettype wire
